// ### inc/mpc_pkg.sv
// Shared constants, carriers and helpers for the multi-mode pin configuration loader.
// Assumes a single 25 MHz clock and synchronous digital views of the pin sense circuits.
package mpc_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int MS_CYC      = CLK_MHZ * 1000;
  localparam int LOAD_MS     = 5;
  localparam int LOAD_CYC    = LOAD_MS * MS_CYC;
  localparam int PRERAMP_MS  = 2;
  localparam int PRERAMP_CYC = PRERAMP_MS * MS_CYC;
  localparam int MIN_OFF_NS  = 150;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;

  localparam int NPINS    = 4;
  localparam int PIN_ADDR = 0;
  localparam int PIN_LVL  = 1;
  localparam int PIN_SS   = 2;
  localparam int PIN_FREQ = 3;

  localparam logic [7:0] R_STATUS  = 8'h00;
  localparam logic [7:0] R_CTRL    = 8'h01;
  localparam logic [7:0] R_VOUT    = 8'h02;
  localparam logic [7:0] R_VMAX    = 8'h03;
  localparam logic [7:0] R_ADDR    = 8'h04;
  localparam logic [7:0] R_FREQ    = 8'h05;
  localparam logic [7:0] R_SS      = 8'h06;
  localparam logic [7:0] R_COMP    = 8'h07;
  localparam logic [7:0] R_UV      = 8'h08;
  localparam logic [7:0] R_OT      = 8'h09;
  localparam logic [7:0] R_OC      = 8'h0A;
  localparam logic [7:0] R_UVLO    = 8'h0B;
  localparam logic [7:0] R_ALERT   = 8'h0C;
  localparam logic [7:0] R_PINKIND = 8'h0D;

  localparam int CTRL_RESTORE = 0;
  localparam int CTRL_OPEN    = 1;
  localparam int AL_UV        = 0;
  localparam int AL_OT        = 1;
  localparam int AL_UVLO      = 2;
  localparam int AL_OC        = 3;

  localparam logic [15:0] VOUT_RST  = 16'h04B0;
  localparam logic [15:0] UV_RST    = 16'h03E8;
  localparam logic [15:0] OT_RST    = 16'h007D;
  localparam logic [15:0] OC_RST    = 16'h2328;
  localparam logic [15:0] UVLO_RST  = 16'h1194;
  localparam logic [7:0]  COMP_RST  = 8'h42;
  localparam logic [15:0] FREQ_LO   = 16'h0064;
  localparam logic [15:0] FREQ_OP   = 16'h0032;
  localparam logic [15:0] FREQ_HI   = 16'h0019;
  localparam logic [15:0] FREQ_BASE = 16'h0010;
  localparam logic [15:0] FREQ_STEP = 16'h0004;
  localparam logic [15:0] SS_LO     = 16'h0000;
  localparam logic [15:0] SS_OP     = 16'h0005;
  localparam logic [15:0] SS_HI     = 16'h000A;
  localparam logic [15:0] SS_STEP   = 16'h0001;
  localparam logic [15:0] ADDR_LO   = 16'h0020;
  localparam logic [15:0] ADDR_OP   = 16'h0021;
  localparam logic [15:0] ADDR_HI   = 16'h0022;
  localparam logic [15:0] ADDR_BASE = 16'h0040;
  localparam logic [15:0] LVL_LO    = 16'h04B0;
  localparam logic [15:0] LVL_OP    = 16'h05DC;
  localparam logic [15:0] LVL_HI    = 16'h0CE4;
  localparam logic [4:0]  CODE_MAX  = 5'h1E;

  localparam logic [15:0] VOUT_TAB [31] = '{
    16'h0258, 16'h02BC, 16'h02EE, 16'h0320, 16'h0384, 16'h03E8, 16'h044C, 16'h04B0,
    16'h04E2, 16'h0514, 16'h0578, 16'h05DC, 16'h0640, 16'h06A4, 16'h0708, 16'h076C,
    16'h07D0, 16'h0834, 16'h0898, 16'h08FC, 16'h0960, 16'h09C4, 16'h0A28, 16'h0A8C,
    16'h0AF0, 16'h0B54, 16'h0BB8, 16'h0C1C, 16'h0C80, 16'h0CE4, 16'h1388};

  typedef enum logic [1:0] {
    PK_LOW  = 2'b00,
    PK_OPEN = 2'b01,
    PK_HIGH = 2'b10,
    PK_RES  = 2'b11
  } mpc_kind_t;

  typedef enum logic [2:0] {
    ST_NVM   = 3'b000,
    ST_PINS  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_DELAY = 3'b011,
    ST_RUN   = 3'b100
  } mpc_state_t;

  typedef struct packed {
    logic       below_lo;
    logic       above_hi;
    logic       res_seen;
    logic [4:0] res_code;
  } mpc_pin_t;

  typedef struct packed {
    logic [15:0] vin_mv;
    logic [15:0] vout_mv;
    logic [15:0] iout_ma;
    logic [15:0] temp_c;
  } mpc_mon_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mpc_req_t;

  function automatic logic [15:0] mpc_pick(mpc_kind_t k, logic [4:0] c, logic [15:0] lo,
                                           logic [15:0] op, logic [15:0] hi,
                                           logic [15:0] base, logic [15:0] step);
    logic [15:0] r;
    r = base + 16'(16'(c) * step);
    if (k == PK_LOW) r = lo;
    else if (k == PK_OPEN) r = op;
    else if (k == PK_HIGH) r = hi;
    return r;
  endfunction

  function automatic logic [15:0] mpc_vout(mpc_kind_t k, logic [4:0] c);
    return mpc_pick(k, c, LVL_LO, LVL_OP, LVL_HI, VOUT_TAB[c], 16'h0000);
  endfunction
endpackage

// ### core/mpc_pin_decode.sv
// Classifies one multi-mode pin from its comparator and resistor sense views.
// Assumes the resistor sense already quantised the resistance into a bin code.
`timescale 1ns/1ns
module mpc_pin_decode (
  input  wire mpc_pkg::mpc_pin_t  pin,
  output mpc_pkg::mpc_kind_t      kind,
  output logic [4:0]              idx
);
  import mpc_pkg::*;

  // A finite resistor pulls the pin partway, so it is checked before the low comparator.
  assign kind = pin.above_hi ? PK_HIGH :
                pin.res_seen ? PK_RES  :
                pin.below_lo ? PK_LOW  : PK_OPEN;
  // Codes past the last bin saturate rather than alias onto a small value.
  assign idx  = (kind == PK_RES) ?
                ((pin.res_code > CODE_MAX) ? CODE_MAX : pin.res_code) :
                {3'b000, kind};
endmodule

// ### core/mpc_pwm.sv
// Constant frequency modulator for the two power switches.
// Assumes the period and duty come from registers of the caller and change at any time.
`timescale 1ns/1ns
module mpc_pwm #(
  parameter int MIN_OFF = mpc_pkg::MIN_OFF_CYC
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic [7:0] duty,
  output logic            hs_on,
  output logic            ls_on
);
  import mpc_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] dmax;
  logic [7:0] dcap;

  assign cnt_nxt = (!run || cnt_r >= period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
  // Short periods could underflow the cap, so the cap floors at zero.
  assign dmax    = (period > 8'(MIN_OFF)) ? period - 8'(MIN_OFF) : 8'h00;
  assign dcap    = (duty > dmax) ? dmax : duty;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      hs_on <= 1'b0;
      ls_on <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hs_on <= run && (cnt_nxt < dcap);
      ls_on <= run && !(cnt_nxt < dcap);
    end
  end

  a_min_low_time: assert property (@(posedge clk) disable iff (!nrst)
    run && period > 8'(MIN_OFF) |-> dcap <= period - 8'(MIN_OFF))
    else $error("duty cap leaves too little low-side time");
  a_switch_excl: assert property (@(posedge clk) disable iff (!nrst)
    !(hs_on && ls_on))
    else $error("both switches on together");
endmodule

// ### core/mpc_loader.sv
// Configuration front end of a digital step-down converter: pin sampling and register port.
// Assumes synchronous pin sense, monitor samples and enable; one 25 MHz clock domain.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
module mpc_loader #(
  parameter int LOAD_CYC    = mpc_pkg::LOAD_CYC,
  parameter int PRERAMP_CYC = mpc_pkg::PRERAMP_CYC,
  parameter int MS_CYC      = mpc_pkg::MS_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire mpc_pkg::mpc_pin_t [3:0]      pins,
  input  wire logic                         en,
  input  wire mpc_pkg::mpc_mon_t            mon,
  input  wire mpc_pkg::mpc_req_t            req,
  output logic [15:0]                       rdata,
  output logic [6:0]                        smbus_addr,
  output logic [15:0]                       vout_max,
  output logic                              ready,
  output logic                              pgood,
  output logic                              alert,
  output logic                              high_side_switch,
  output logic                              low_side_switch
);
  import mpc_pkg::*;

  mpc_state_t  state_r;
  mpc_state_t  state_nxt;
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic [23:0] delay_cyc;
  mpc_kind_t   kind [NPINS];
  logic [4:0]  idx [NPINS];
  logic [7:0]  kinds_r;
  logic [15:0] vout_r;
  logic [15:0] vmax_r;
  logic [6:0]  addr_r;
  logic [7:0]  freq_r;
  logic [15:0] ss_r;
  logic [7:0]  comp_r;
  logic [15:0] uv_r;
  logic [15:0] ot_r;
  logic [15:0] oc_r;
  logic [15:0] uvlo_r;
  logic        open_r;
  logic [3:0]  alert_r;
  logic [3:0]  alert_set;
  logic [3:0]  alert_clr;
  logic [15:0] rdata_nxt;
  logic [15:0] lvl_mv;
  logic [16:0] vmax_calc;
  logic        busy;
  logic        wr_ok;
  logic        rd_ok;
  logic        restore;
  logic        sample;
  logic        running;
  logic        enable;
  logic signed [23:0] err;
  logic signed [23:0] p_term;
  logic signed [23:0] integ_r;
  logic signed [23:0] sum;
  logic [7:0]  duty_r;
  logic [7:0]  duty_nxt;

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    mpc_pin_decode u_dec (
      .pin  (pins[i]),
      .kind (kind[i]),
      .idx  (idx[i])
    );
  end

  // Loading window: bus and enable are both ignored until the pins are in.
  assign busy      = (state_r == ST_NVM) || (state_r == ST_PINS);
  assign wr_ok     = req.wr && !busy;
  assign rd_ok     = req.rd && !busy;
  assign restore   = wr_ok && (req.addr == R_CTRL) && req.wdata[CTRL_RESTORE];
  assign sample    = (state_r == ST_PINS);
  assign running   = (state_r == ST_RUN);
  assign enable    = (en || open_r) && (mon.vin_mv >= uvlo_r);
  assign delay_cyc = 24'(PRERAMP_CYC) + 24'(32'(ss_r) * MS_CYC);
  assign lvl_mv    = mpc_vout(kind[PIN_LVL], idx[PIN_LVL]);
  assign vmax_calc = 17'(({1'b0, lvl_mv} * 17'h0000B) / 17'h0000A);

  // Sequencer.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 24'h000001;
    case (state_r)
      ST_NVM: begin
        if (cnt_r >= 24'(LOAD_CYC - 1)) begin
          state_nxt = ST_PINS;
        end
      end
      ST_PINS: begin
        state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        cnt_nxt = 24'h000000;
        if (enable) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!enable) begin
          state_nxt = ST_IDLE;
        end else if (cnt_r >= delay_cyc - 24'h000001) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_NVM;
      end
    endcase
    if (restore) begin
      state_nxt = ST_NVM;
    end
    if (state_nxt != state_r) begin
      cnt_nxt = 24'h000000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_NVM;
      cnt_r   <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Pin-fixed values: written only by sampling, never by the bus.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_r  <= 7'h00;
      vmax_r  <= 16'h0000;
      kinds_r <= 8'h00;
    end else if (sample) begin
      addr_r  <= 7'(mpc_pick(kind[PIN_ADDR], idx[PIN_ADDR], ADDR_LO, ADDR_OP,
                             ADDR_HI, ADDR_BASE, 16'h0001));
      vmax_r  <= vmax_calc[15:0];
      kinds_r <= {kind[3], kind[2], kind[1], kind[0]};
    end
  end

  // Overridable values: pins load vout, freq and ss, reset sets the rest; later bus writes replace them.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vout_r <= VOUT_RST;
      freq_r <= FREQ_LO[7:0];
      ss_r   <= SS_LO;
      comp_r <= COMP_RST;
      uv_r   <= UV_RST;
      ot_r   <= OT_RST;
      oc_r   <= OC_RST;
      uvlo_r <= UVLO_RST;
      open_r <= 1'b0;
    end else if (sample) begin
      vout_r <= lvl_mv;
      freq_r <= 8'(mpc_pick(kind[PIN_FREQ], idx[PIN_FREQ], FREQ_LO, FREQ_OP,
                            FREQ_HI, FREQ_BASE, FREQ_STEP));
      ss_r   <= mpc_pick(kind[PIN_SS], idx[PIN_SS], SS_LO, SS_OP, SS_HI,
                         16'h0000, SS_STEP);
    end else if (wr_ok) begin
      if (req.addr == R_VOUT) vout_r <= req.wdata;
      else if (req.addr == R_FREQ) freq_r <= req.wdata[7:0];
      else if (req.addr == R_SS) ss_r <= req.wdata;
      else if (req.addr == R_COMP) comp_r <= req.wdata[7:0];
      else if (req.addr == R_UV) uv_r <= req.wdata;
      else if (req.addr == R_OT) ot_r <= req.wdata;
      else if (req.addr == R_OC) oc_r <= req.wdata;
      else if (req.addr == R_UVLO) uvlo_r <= req.wdata;
      else if (req.addr == R_CTRL) open_r <= req.wdata[CTRL_OPEN];
    end
  end

  // Monitors: sticky alerts, a new event beats a same-cycle clear.
  assign alert_set[AL_UV]   = running && (mon.vout_mv < uv_r);
  assign alert_set[AL_OT]   = mon.temp_c > ot_r;
  assign alert_set[AL_UVLO] = !busy && (mon.vin_mv < uvlo_r);
  assign alert_set[AL_OC]   = mon.iout_ma > oc_r;
  assign alert_clr          = (wr_ok && req.addr == R_ALERT) ? req.wdata[3:0] : 4'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_r <= 4'h0;
    end else begin
      alert_r <= (alert_r & ~alert_clr) | alert_set;
    end
  end

  // Compensation: gain and integral shift are packed in one register.
  assign err      = 24'(signed'({8'h00, vout_r})) - 24'(signed'({8'h00, mon.vout_mv}));
  assign p_term   = err >>> comp_r[3:0];
  assign sum      = p_term + integ_r;
  assign duty_nxt = sum[23] ? 8'h00 : (sum > 24'sh0000FF) ? 8'hFF : sum[7:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integ_r <= 24'sh000000;
      duty_r  <= 8'h00;
    end else if (!running) begin
      integ_r <= 24'sh000000;
      duty_r  <= 8'h00;
    end else begin
      integ_r <= integ_r + (err >>> comp_r[7:4]);
      duty_r  <= duty_nxt;
    end
  end

  mpc_pwm u_pwm (
    .clk    (clk),
    .nrst   (nrst),
    .run    (running),
    .period (freq_r),
    .duty   (duty_r),
    .hs_on  (high_side_switch),
    .ls_on  (low_side_switch)
  );

  // Read decode; traffic during loading reads back as zero.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (!rd_ok) rdata_nxt = 16'h0000;
    else if (req.addr == R_STATUS) rdata_nxt = {11'h000, pgood, ready, state_r};
    else if (req.addr == R_CTRL) rdata_nxt = {14'h0000, open_r, 1'b0};
    else if (req.addr == R_VOUT) rdata_nxt = vout_r;
    else if (req.addr == R_VMAX) rdata_nxt = vmax_r;
    else if (req.addr == R_ADDR) rdata_nxt = {9'h000, addr_r};
    else if (req.addr == R_FREQ) rdata_nxt = {8'h00, freq_r};
    else if (req.addr == R_SS) rdata_nxt = ss_r;
    else if (req.addr == R_COMP) rdata_nxt = {8'h00, comp_r};
    else if (req.addr == R_UV) rdata_nxt = uv_r;
    else if (req.addr == R_OT) rdata_nxt = ot_r;
    else if (req.addr == R_OC) rdata_nxt = oc_r;
    else if (req.addr == R_UVLO) rdata_nxt = uvlo_r;
    else if (req.addr == R_ALERT) rdata_nxt = {12'h000, alert_r};
    else if (req.addr == R_PINKIND) rdata_nxt = {8'h00, kinds_r};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
      ready <= 1'b0;
      pgood <= 1'b0;
      alert <= 1'b0;
    end else begin
      rdata <= rdata_nxt;
      ready <= !busy && !(state_nxt == ST_NVM);
      pgood <= (state_nxt == ST_RUN) && (mon.vout_mv >= uv_r);
      alert <= |((alert_r & ~alert_clr) | alert_set);
    end
  end

  assign smbus_addr = addr_r;
  assign vout_max   = vmax_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_addr_pin_only: assert property ($changed(addr_r) |-> $past(state_r) == ST_PINS)
    else $error("address changed outside sampling");
  a_vmax_ratio: assert property (sample |=> vout_max ==
    16'(({1'b0, $past(lvl_mv)} * 17'h0000B) / 17'h0000A))
    else $error("vout max not 110 percent of pin level");
  a_sample_source: assert property ($changed(kinds_r) |-> $past(sample))
    else $error("pins resampled outside load");
  a_bus_override: assert property (wr_ok && req.addr == R_VOUT |=>
    vout_r == $past(req.wdata))
    else $error("bus write did not override");
  a_read_back: assert property (rd_ok && req.addr == R_VOUT |=> rdata == $past(vout_r))
    else $error("read back mismatch");
  a_busy_ignore: assert property (state_r == ST_NVM && req.wr |=> $stable(ss_r))
    else $error("write taken while loading");
  a_load_bound: assert property (state_r == ST_NVM |-> cnt_r < 24'(LOAD_CYC))
    else $error("load window overran");
  a_pgood_run: assert property (pgood |-> $past(state_nxt) == ST_RUN)
    else $error("power good outside run");
  a_run_after_delay: assert property ($rose(running) |-> $past(state_r) == ST_DELAY)
    else $error("ramp without pre-ramp delay");
  a_alert_sticky: assert property (alert_r[AL_OT] && !alert_clr[AL_OT] |=>
    alert_r[AL_OT])
    else $error("alert bit dropped");

  c_restore: cover property (restore ##1 state_r == ST_NVM);
  c_run: cover property ($rose(running));
  c_alert: cover property ($rose(alert));
endmodule

// ### sim/mpc_strap_model.sv
// Far-side strap network of the four multi-mode pins, seen through their sense circuits.
// Assumes the bench picks a connection kind (2 bits a pin) and one resistor bin for all.
`timescale 1ns/1ns
module mpc_strap_model (
  input  wire logic [7:0]            conn,
  input  wire logic [4:0]            code,
  output mpc_pkg::mpc_pin_t [3:0]    pins
);
  import mpc_pkg::*;

  logic [4:0] bin_code;

  // Only every fourth 1% step is fitted, so the sensed value never straddles two bins.
  assign bin_code = (code > CODE_MAX) ? CODE_MAX : code;

  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign pins[i].below_lo = (conn[2*i+:2] == 2'b00);
    assign pins[i].above_hi = (conn[2*i+:2] == 2'b10);
    assign pins[i].res_seen = (conn[2*i+:2] == 2'b11);
    // A strapped pin has no resistor, so the code view shows a value that must be ignored.
    assign pins[i].res_code = (conn[2*i+:2] == 2'b11) ? bin_code : ~bin_code;
  end
endmodule

// ### sim/mpc_loader_tb_top.sv
// Self-checking bench for the pin configuration loader and its register port.
// Assumes shortened load and delay counts; the strap model stands in for the board.
`timescale 1ns/1ns
module mpc_loader_tb_top;
  import mpc_pkg::*;

  logic           clk;
  logic           nrst;
  logic           en;
  mpc_mon_t       mon;
  mpc_req_t       req;
  mpc_pin_t [3:0] pins;
  logic [7:0]     conn;
  logic [4:0]     code;
  logic [15:0]    rdata;
  logic [15:0]    vout_max;
  logic [15:0]    v;
  logic [6:0]     smbus_addr;
  logic [6:0]     a0;
  logic           ready;
  logic           pgood;
  logic           alert;
  logic           hs;
  logic           ls;
  int             err_count;
  int             n_checks;
  int             cyc;
  int             n;
  int             nh;
  int             nl;

  mpc_strap_model strap (.conn(conn), .code(code), .pins(pins));

  mpc_loader #(.LOAD_CYC(20), .PRERAMP_CYC(10), .MS_CYC(4)) uut (
    .clk(clk), .nrst(nrst), .pins(pins), .en(en), .mon(mon), .req(req), .rdata(rdata),
    .smbus_addr(smbus_addr), .vout_max(vout_max), .ready(ready), .pgood(pgood),
    .alert(alert), .high_side_switch(hs), .low_side_switch(ls));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] dv);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dv};
    @(posedge clk) req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just then.
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk) req <= '0;
    #1 chk(rdata, exp);
  endtask

  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(ready), 16'h0001);
  endtask

  function automatic logic [15:0] sel(int k, logic [15:0] lo, logic [15:0] op,
                                      logic [15:0] hi, logic [15:0] rv);
    return (k == 0) ? lo : (k == 1) ? op : (k == 2) ? hi : rv;
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hs === 1'b1 && ls === 1'b1) chk(16'h0001, 16'h0000);
    if (cyc == 8000) begin
      err_count++;
      tally_and_finish();
    end
  end

  always @(posedge hs) nh++;
  always @(posedge ls) nl++;

  initial begin
    nrst = 1'b0;
    en = 1'b0;
    req = '0;
    conn = 8'hE4;
    code = 5'h05;
    mon = '{vin_mv: 16'h1388, vout_mv: 16'h03E8, iout_ma: 16'h03E8, temp_c: 16'h0019};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wr(R_VOUT, 16'h0999);
    rchk(R_VOUT, 16'h0000);
    wait_ready();
    chk(16'(smbus_addr), ADDR_LO);
    chk(vout_max, 16'h0672);
    rchk(R_VOUT, LVL_OP);
    rchk(R_SS, SS_HI);
    rchk(R_FREQ, 16'h0024);
    rchk(R_PINKIND, 16'h00E4);
    for (int k = 0; k < 4; k++) begin
      a0 = smbus_addr;
      @(posedge clk) conn <= 8'(k * 8'h55);
      code <= 5'h1E;
      repeat (4) @(posedge clk);
      #1 chk(16'(smbus_addr), 16'(a0));
      wr(R_CTRL, 16'h0001);
      #1 chk(16'(ready), 16'h0000);
      rchk(R_SS, 16'h0000);
      wait_ready();
      v = sel(k, LVL_LO, LVL_OP, LVL_HI, VOUT_TAB[30]);
      chk(vout_max, 16'(v * 11 / 10));
      chk(16'(smbus_addr), sel(k, ADDR_LO, ADDR_OP, ADDR_HI, ADDR_BASE + 16'h001E));
      rchk(R_VOUT, v);
      rchk(R_FREQ, sel(k, FREQ_LO, FREQ_OP, FREQ_HI, FREQ_BASE + 16'h001E * FREQ_STEP));
      rchk(R_SS, sel(k, SS_LO, SS_OP, SS_HI, 16'h001E));
      rchk(R_PINKIND, 16'(k * 8'h55));
    end
    wr(R_ADDR, 16'h007F);
    wr(R_VMAX, 16'h0001);
    wr(R_VOUT, 16'h0708);
    wr(R_SS, 16'h0000);
    wr(R_FREQ, 16'h0020);
    rchk(R_ADDR, 16'h005E);
    chk(16'(smbus_addr), 16'h005E);
    rchk(R_VMAX, 16'h157C);
    rchk(R_VOUT, 16'h0708);
    rchk(R_SS, 16'h0000);
    rchk(8'h20, 16'h0000);
    // Input below the lockout level must keep the converter off despite the enable.
    @(posedge clk) mon.vin_mv <= 16'h0FA0;
    en <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk(16'(pgood), 16'h0000);
    @(posedge clk) mon.vin_mv <= 16'h1388;
    n = 0;
    while (pgood !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n >= 10 && n <= 14), 16'h0001);
    nh = 0;
    nl = 0;
    repeat (200) @(posedge clk);
    chk(16'(nh >= 5), 16'h0001);
    chk(16'(nl >= nh - 1), 16'h0001);
    rchk(R_STATUS, 16'h001C);
    rchk(R_ALERT, 16'h0004);
    chk(16'(alert), 16'h0001);
    wr(R_ALERT, 16'h000F);
    @(posedge clk) mon.temp_c <= 16'h00C8;
    repeat (3) @(posedge clk);
    #1 chk(16'(alert), 16'h0001);
    @(posedge clk) mon.temp_c <= 16'h0019;
    rchk(R_ALERT, 16'h0002);
    wr(R_ALERT, 16'h0002);
    rchk(R_ALERT, 16'h0000);
    chk(16'(alert), 16'h0000);
    @(posedge clk) en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(16'(pgood), 16'h0000);
    // The bus enable bit stands in for the pin when a host runs the converter.
    wr(R_CTRL, 16'h0002);
    repeat (14) @(posedge clk);
    #1 chk(16'(pgood), 16'h0001);
    rchk(R_CTRL, 16'h0002);
    tally_and_finish();
  end
endmodule
